// ==== common/ocmp_pkg.sv ====
/*
  Constants, types and register layout for the output compare channel.
  Assumes one clock domain and a plain strobe register port.
*/
`default_nettype none
// Overview of operation
// - Timebase-select 1 picks the second timebase, 0 picks the first.
// - The count is compared against one or two values, per the mode field.
// - The output pin changes when the timebase equals the relevant value.
// - Mode 000 disables the channel, raises no event and frees the pin.
// - Mode 001 starts low, goes high on a match, events on that rise.
// - Mode 010 starts high, goes low on a match, events on that fall.
// - Mode 011 keeps the entry level, toggles per match, events both edges.
// - Mode 100 starts low, emits one delayed pulse, events on its fall.
// - Mode 101 starts low, emits repeated pulses, events on each fall.
// - Mode 110 is PWM without fault, starts at primary!=0, no event.
// - Mode 111 is PWM with fault, same start, events on a fault fall.
// - The read-only fault flag is set by a fault in mode 111, a control write clears it.
// - With idle-stop set the channel halts while the CPU idles.
// - Control bits 15:14 and 12:5 read as zero.
package ocmp_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned EVT_W = 2;
  // ==========================================================
  // Register indexes.
  localparam logic [2:0] CTRL_IDX = 3'h0;
  localparam logic [2:0] PRI_IDX = 3'h1;
  localparam logic [2:0] SEC_IDX = 3'h2;
  localparam logic [2:0] STAT_IDX = 3'h3;
  localparam logic [2:0] MASK_IDX = 3'h4;
  // ==========================================================
  // Field positions and reset values.
  localparam int unsigned TSEL_BIT = 3;
  localparam int unsigned FLT_BIT = 4;
  localparam int unsigned IDLE_BIT = 13;
  localparam logic [15:0] CTRL_WMASK = 16'h200f;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam int unsigned EV_CMP = 0;
  localparam int unsigned EV_FLT = 1;
  localparam int unsigned SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    M_OFF = 3'h0, M_ONE_HI = 3'h1, M_ONE_LO = 3'h2, M_TOGGLE = 3'h3,
    M_DELAY = 3'h4, M_CONT = 3'h5, M_PWM = 3'h6, M_PWM_FLT = 3'h7
  } mode_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;
endpackage
`default_nettype wire

// ==== hdl/output_compare_channel.sv ====
/*
  Single output compare channel with register port and interrupt.
  Assumes timebases, cpu_idle and the bus come from ref_clk logic; the
  fault input is an asynchronous pin.
*/
`timescale 1ns/1ns
`default_nettype none
module output_compare_channel #(
  parameter int unsigned DW = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire ocmp_pkg::bus_req_s bus_req,
  output logic [15:0] bus_rdata,
  input wire logic [15:0] first_timebase,
  input wire logic [15:0] second_timebase,
  input wire logic cpu_idle,
  input wire logic fault_input,
  output logic compare_output_pin,
  output logic compare_output_oe,
  output logic irq
);
  import ocmp_pkg::*;

  // ==========================================================
  // Elaboration check.
  if (DW != DATA_W) begin : g_bad_width
    $error("DW must equal the 16-bit register layout.");
  end

  // ==========================================================
  // Registers.
  logic [15:0] ctrl_q, pri_q, sec_q;
  logic [EVT_W-1:0] stat_q, stat_d, mask_q;
  logic flt_q, flt_d;
  logic out_q, out_d;
  logic done_q, done_d;
  logic [15:0] tb_prev_q;
  logic [15:0] rdata_q, rdata_d;
  logic [SYNC_STAGES:0] fsync_q;

  // ==========================================================
  // Bus decode.
  wire logic wr_ctrl = bus_req.wr && bus_req.addr == CTRL_IDX;
  wire logic wr_pri = bus_req.wr && bus_req.addr == PRI_IDX;
  wire logic wr_sec = bus_req.wr && bus_req.addr == SEC_IDX;
  wire logic wr_stat = bus_req.wr && bus_req.addr == STAT_IDX;
  wire logic wr_mask = bus_req.wr && bus_req.addr == MASK_IDX;
  wire mode_e mode = mode_e'(ctrl_q[2:0]);
  wire mode_e new_mode = mode_e'(bus_req.wdata[2:0]);

  // ==========================================================
  // Timebase selection and match detection.
  // A match counts only when the count has just moved, so a timer
  // stopped on the compare value does not fire every cycle.
  wire logic [15:0] tb_sel = ctrl_q[TSEL_BIT] ? second_timebase : first_timebase;
  wire logic halt = ctrl_q[IDLE_BIT] && cpu_idle;
  wire logic tb_moved = tb_sel != tb_prev_q;
  wire logic hit_pri = !halt && tb_moved && tb_sel == pri_q;
  wire logic hit_sec = !halt && tb_moved && tb_sel == sec_q;
  wire logic hit_zero = !halt && tb_moved && tb_sel == 16'h0000;

  // Fault pin passes two flops; the third only feeds the edge detector.
  wire logic flt_fall = fsync_q[SYNC_STAGES] && !fsync_q[SYNC_STAGES-1];
  wire logic ev_flt = mode == M_PWM_FLT && flt_fall;

  // Output level taken when a mode is entered.
  function automatic logic init_level(mode_e m, logic [15:0] p, logic cur);
    unique case (m)
      M_ONE_LO: init_level = 1'b1;
      M_TOGGLE: init_level = cur;
      M_PWM, M_PWM_FLT: init_level = p != 16'h0000;
      default: init_level = 1'b0;
    endcase
  endfunction

  // Edges that raise the compare event in each mode.
  function automatic logic edge_event(mode_e m, logic rise, logic fall);
    unique case (m)
      M_ONE_HI: edge_event = rise;
      M_ONE_LO: edge_event = fall;
      M_TOGGLE: edge_event = rise || fall;
      M_DELAY, M_CONT: edge_event = fall;
      default: edge_event = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Output sequencing.
  always_comb begin
    out_d = out_q;
    done_d = done_q;
    if (wr_ctrl) begin
      out_d = init_level(new_mode, pri_q, out_q);
      done_d = 1'b0;
    end else begin
      unique case (mode)
        M_ONE_HI: if (hit_pri) out_d = 1'b1;
        M_ONE_LO: if (hit_pri) out_d = 1'b0;
        M_TOGGLE: if (hit_pri) out_d = !out_q;
        M_DELAY, M_CONT: begin
          if (!done_q && hit_pri) begin
            out_d = 1'b1;
          end
          if (!done_q && hit_sec && out_q) begin
            out_d = 1'b0;
            done_d = mode == M_DELAY;
          end
        end
        M_PWM, M_PWM_FLT: begin
          if (hit_zero) begin
            out_d = pri_q != 16'h0000;
          end else if (hit_pri) begin
            out_d = 1'b0;
          end
        end
        default: out_d = 1'b0;
      endcase
      // The fault overrides even a halted channel, for safety.
      if (mode == M_PWM_FLT && (flt_q || flt_fall)) begin
        out_d = 1'b0;
      end
    end
  end

  wire logic out_rise = out_d && !out_q;
  wire logic out_fall = !out_d && out_q;
  wire logic ev_cmp = !wr_ctrl && edge_event(mode, out_rise, out_fall);

  // Fault flag: software cannot write it; a control rewrite clears it,
  // and a fault in the same cycle still wins.
  assign flt_d = ev_flt || (flt_q && !wr_ctrl);

  // Sticky status, write one to clear, set wins over clear.
  wire logic [EVT_W-1:0] ev_vec = {ev_flt, ev_cmp};
  wire logic [EVT_W-1:0] clr_vec = wr_stat ? bus_req.wdata[EVT_W-1:0] : '0;
  assign stat_d = ev_vec | (stat_q & ~clr_vec);

  // ==========================================================
  // Read mux; unmapped indexes read zero.
  wire logic [15:0] ctrl_view = {2'b00, ctrl_q[IDLE_BIT], 8'h00, flt_q, ctrl_q[3:0]};
  always_comb begin
    rdata_d = 16'h0000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CTRL_IDX: rdata_d = ctrl_view;
        PRI_IDX: rdata_d = pri_q;
        SEC_IDX: rdata_d = sec_q;
        STAT_IDX: rdata_d = {14'h0000, stat_q};
        MASK_IDX: rdata_d = {14'h0000, mask_q};
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // Register file. Timebase must be stopped before control writes.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_q <= REG_RST;
      pri_q <= REG_RST;
      sec_q <= REG_RST;
      mask_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q <= bus_req.wdata & CTRL_WMASK;
      if (wr_pri) pri_q <= bus_req.wdata;
      if (wr_sec) sec_q <= bus_req.wdata;
      if (wr_mask) mask_q <= bus_req.wdata[EVT_W-1:0];
    end
  end

  // Channel state.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_q <= 1'b0;
      done_q <= 1'b0;
      flt_q <= 1'b0;
      stat_q <= '0;
      tb_prev_q <= REG_RST;
      rdata_q <= REG_RST;
      fsync_q <= '1;
    end else begin
      out_q <= out_d;
      done_q <= done_d;
      flt_q <= flt_d;
      stat_q <= stat_d;
      tb_prev_q <= tb_sel;
      rdata_q <= rdata_d;
      fsync_q <= {fsync_q[SYNC_STAGES-1:0], fault_input};
    end
  end

  // ==========================================================
  // Outputs. The pin is released to port logic in mode 000.
  assign compare_output_pin = out_q;
  assign compare_output_oe = mode != M_OFF;
  assign irq = |(stat_q & mask_q);
  assign bus_rdata = rdata_q;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_fault_seen;
    mode == M_PWM_FLT && flt_fall && !wr_ctrl;
  endsequence

  sequence s_fault_held;
    (!out_q && flt_q) [*2];
  endsequence

  a_off_silent: assert property (
    mode == M_OFF |-> !ev_cmp && !compare_output_oe && !out_q)
    else $error("Disabled channel raised an event or drove the pin.");

  a_oneshot_rise: assert property (
    mode == M_ONE_HI && hit_pri && !out_q && !wr_ctrl |=> out_q && stat_q[EV_CMP])
    else $error("Mode 001 match did not drive high with an event.");

  a_oneshot_fall: assert property (
    mode == M_ONE_LO && hit_pri && !wr_ctrl |=> !out_q)
    else $error("Mode 010 match did not drive low.");

  a_toggle_flip: assert property (
    mode == M_TOGGLE && hit_pri && !wr_ctrl |=> out_q != $past(out_q))
    else $error("Toggle mode did not invert on a match.");

  a_pulse_rise: assert property (
    mode == M_CONT && hit_pri && !hit_sec && !wr_ctrl && !done_q |=> out_q)
    else $error("Pulse mode did not rise on a primary match.");

  a_pwm_quiet: assert property (
    mode == M_PWM |-> !ev_cmp && !ev_flt)
    else $error("PWM without fault raised an event.");

  a_fault_hold: assert property (
    s_fault_seen ##1 !wr_ctrl |-> s_fault_held)
    else $error("Fault did not hold the pin low.");

  a_fault_sticky: assert property (
    flt_q && !wr_ctrl |=> flt_q)
    else $error("Fault flag dropped without a control write.");

  a_idle_halt: assert property (
    ctrl_q[IDLE_BIT] && cpu_idle && !wr_ctrl && mode != M_PWM_FLT
      |-> (!hit_pri && !hit_sec) ##1 (out_q == $past(out_q)))
    else $error("Channel matched while halted in idle.");

  a_rsvd_zero: assert property (
    bus_req.rd && bus_req.addr == CTRL_IDX |=> bus_rdata[15:14] == 2'b00
      && bus_rdata[12:5] == 8'h00)
    else $error("Unimplemented control bits read nonzero.");

  // Output level right after a control write, per the new mode.
  a_low_entry: assert property (
    wr_ctrl && (new_mode == M_ONE_HI || new_mode == M_DELAY || new_mode == M_CONT)
      |=> !out_q)
    else $error("Channel did not start low after a mode write.");

  a_high_entry: assert property (
    wr_ctrl && new_mode == M_ONE_LO |=> out_q)
    else $error("Mode 010 did not start high.");

  a_toggle_entry: assert property (
    wr_ctrl && new_mode == M_TOGGLE |=> out_q == $past(out_q))
    else $error("Toggle mode did not keep the entry level.");

  a_pwm_entry: assert property (
    wr_ctrl && (new_mode == M_PWM || new_mode == M_PWM_FLT)
      |=> out_q == ($past(pri_q) != 16'h0000))
    else $error("PWM did not start at the level set by the primary value.");

  // PWM period: the count reaching zero opens the duty, the primary match ends it.
  a_pwm_period: assert property (
    mode == M_PWM && hit_zero && !wr_ctrl |=> out_q == ($past(pri_q) != 16'h0000))
    else $error("PWM did not open its period at a zero count.");

  a_pwm_duty: assert property (
    mode == M_PWM && hit_pri && !hit_zero && !wr_ctrl |=> !out_q)
    else $error("PWM did not end its duty on a primary match.");

  // Pulse modes: the secondary match closes the pulse, and one-shot then stays low.
  a_pulse_fall: assert property (
    mode == M_CONT && hit_sec && out_q && !wr_ctrl |=> !out_q && stat_q[EV_CMP])
    else $error("Pulse mode did not fall with an event on a secondary match.");

  a_delay_stop: assert property (
    mode == M_DELAY && done_q && !wr_ctrl |=> !out_q)
    else $error("Delayed one-shot pulsed a second time.");

  // Fault capture and the flag that it leaves behind.
  a_fault_set: assert property (
    s_fault_seen |=> flt_q && stat_q[EV_FLT])
    else $error("Fault did not set the flag and its event.");

  a_flag_pwm_only: assert property (
    mode != M_PWM_FLT && !flt_q |=> !flt_q)
    else $error("Fault flag rose outside PWM with fault.");

  a_sel_timebase: assert property (
    hit_pri |-> pri_q == (ctrl_q[TSEL_BIT] ? second_timebase : first_timebase))
    else $error("Primary match taken from the wrong timebase.");
endmodule
`default_nettype wire

// ==== dv/fault_source.sv ====
/*
  Behavioural model of the circuit on the far side of the compare pin.
  Assumes the bench commands when the fault line is pulled low.
*/
`timescale 1ns/1ns
`default_nettype none
module fault_source (
  input wire logic ref_clk,
  input wire logic pull_low,
  input wire logic compare_output_pin,
  output logic fault_input
);
  // ==========================================
  // Fault line: pulled up at rest, low only while the bench asks.
  // The line changes after the clock edge, as a real pin would be asynchronous.
  initial fault_input = 1'b1;
  always @(posedge ref_clk) begin
    fault_input <= #3 ~pull_low;
  end
endmodule
`default_nettype wire

// ==== dv/tb_output_compare_channel.sv ====
/*
  Self-checking bench of the output compare channel.
  Assumes the package and fault_source are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_output_compare_channel;
  import ocmp_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  bus_req_s bus_req = '0;
  logic [15:0] bus_rdata, tb1 = '0, tb2 = '0, rv;
  logic cpu_idle = 1'b0, pull_low = 1'b0;
  logic fault_input, pin, oe, irq;
  int num_errors = 0, comparisons = 0, cycles = 0;
  output_compare_channel u_dut (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .first_timebase(tb1), .second_timebase(tb2),
    .cpu_idle(cpu_idle), .fault_input(fault_input), .compare_output_pin(pin),
    .compare_output_oe(oe), .irq(irq));
  fault_source u_far (.ref_clk(ref_clk), .pull_low(pull_low),
    .compare_output_pin(pin), .fault_input(fault_input));
  // ==========================================
  // Clock and a cycle ceiling so a hang still ends in a verdict.
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  // ==========================================
  // Register port: one-cycle strobes, read data taken in the following cycle.
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    // Timebases move only inside step, so every control write finds them still.
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  // Move the chosen timebase, then look at the pin once the match has landed.
  task automatic step(input bit sel2, input logic [15:0] v, input logic exp);
    @(posedge ref_clk);
    if (sel2) tb2 <= v;
    else tb1 <= v;
    repeat (2) @(posedge ref_clk);
    #1 chk({15'h0, pin}, {15'h0, exp});
  endtask
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_regs();
    wr(CTRL_IDX, 16'hffff);
    rd(CTRL_IDX, rv);
    chk(rv, 16'h200f);
    rd(3'h7, rv);
    chk(rv, 16'h0000);
    wr(CTRL_IDX, 16'h0000);
    settle();
    chk({15'h0, oe}, 16'h0000);
  endtask
  task automatic t_one_shots();
    wr(PRI_IDX, 16'h0005);
    wr(MASK_IDX, 16'h0003);
    wr(CTRL_IDX, 16'h0001);
    settle();
    chk({15'h0, pin}, 16'h0000);
    step(1'b1, 16'h0005, 1'b0);
    step(1'b0, 16'h0005, 1'b1);
    chk({15'h0, irq}, 16'h0001);
    wr(STAT_IDX, 16'h0003);
    settle();
    chk({15'h0, irq}, 16'h0000);
    wr(CTRL_IDX, 16'h000a);
    settle();
    chk({15'h0, pin}, 16'h0001);
    step(1'b0, 16'h0000, 1'b1);
    step(1'b0, 16'h0005, 1'b1);
    step(1'b1, 16'h0000, 1'b1);
    step(1'b1, 16'h0005, 1'b0);
    rd(STAT_IDX, rv);
    chk(rv, 16'h0001);
  endtask
  task automatic t_toggle_pulse();
    wr(STAT_IDX, 16'h0003);
    wr(CTRL_IDX, 16'h0003);
    step(1'b0, 16'h0001, 1'b0);
    step(1'b0, 16'h0005, 1'b1);
    step(1'b0, 16'h0000, 1'b1);
    step(1'b0, 16'h0005, 1'b0);
    wr(PRI_IDX, 16'h0003);
    wr(SEC_IDX, 16'h0006);
    wr(STAT_IDX, 16'h0003);
    wr(CTRL_IDX, 16'h0004);
    step(1'b0, 16'h0006, 1'b0);
    step(1'b0, 16'h0003, 1'b1);
    chk({15'h0, irq}, 16'h0000);
    step(1'b0, 16'h0006, 1'b0);
    chk({15'h0, irq}, 16'h0001);
    step(1'b0, 16'h0003, 1'b0);
    wr(CTRL_IDX, 16'h0005);
    step(1'b0, 16'h0000, 1'b0);
    for (int i = 0; i < 2; i++) begin
      step(1'b0, 16'h0003, 1'b1);
      step(1'b0, 16'h0006, 1'b0);
    end
  endtask
  task automatic t_idle();
    wr(CTRL_IDX, 16'h2001);
    cpu_idle <= 1'b1;
    step(1'b0, 16'h0003, 1'b0);
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
    step(1'b0, 16'h0000, 1'b0);
    step(1'b0, 16'h0003, 1'b1);
    // With idle-stop clear the channel keeps matching while the CPU idles.
    wr(CTRL_IDX, 16'h0001);
    cpu_idle <= 1'b1;
    step(1'b0, 16'h0000, 1'b0);
    step(1'b0, 16'h0003, 1'b1);
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
  endtask
  task automatic t_pwm();
    wr(PRI_IDX, 16'h0000);
    wr(STAT_IDX, 16'h0003);
    wr(CTRL_IDX, 16'h0006);
    settle();
    chk({15'h0, pin}, 16'h0000);
    wr(PRI_IDX, 16'h0005);
    step(1'b0, 16'h0000, 1'b1);
    step(1'b0, 16'h0005, 1'b0);
    wr(CTRL_IDX, 16'h0007);
    settle();
    chk({15'h0, pin}, 16'h0001);
    @(posedge ref_clk);
    pull_low <= 1'b1;
    repeat (6) @(posedge ref_clk);
    pull_low <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 chk({15'h0, pin}, 16'h0000);
    rd(CTRL_IDX, rv);
    chk(rv, 16'h0017);
    rd(STAT_IDX, rv);
    chk(rv, 16'h0002);
    step(1'b0, 16'h0000, 1'b0);
  endtask
  // ==========================================
  // Main sequence: reset held for twelve cycles, then the scenarios.
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    chk({13'h0, pin, oe, irq}, 16'h0000);
    t_regs();
    t_one_shots();
    t_toggle_pulse();
    t_idle();
    t_pwm();
    test_done();
  end
endmodule
`default_nettype wire
